//--- hsd_regs.svh
`ifndef HSD_REGS_SVH
`define HSD_REGS_SVH

// ****************************************
// Device register offsets, page 0
// ****************************************
`define P0_SOFT_RESET 7'h01
`define P0_FLAGS_A 7'h2A
`define P0_EVENT_FLAGS 7'h2C
`define P0_FLAGS_C 7'h2D
`define P0_LIVE_STATUS 7'h2E
`define P0_IRQ1_CFG 7'h30
`define P0_IRQ2_CFG 7'h31
`define P0_GPIO_CTL 7'h34
`define P0_DOUT_CTL 7'h35
`define P0_MISO_CTL 7'h37
`define P0_PLUG_CTL 7'h43
// ****************************************
// Device register offsets, page 1
// ****************************************
`define P1_CRUDE_CTL 7'h01
`define P1_ANALOG_CTL 7'h02
`define P1_REF_CTL 7'h7B
`define PAGE_SELECT 7'h00

// ****************************************
// Field positions
// ****************************************
`define SOFT_RESET_BIT 0
`define BTN_FLAG_BIT 5
`define PLUG_FLAG_BIT 4
`define OC_FLAG_BIT 3
`define DET_EN_BIT 1
`define TYPE_LSB 5
`define PULSE_SERIES_BIT 0
`define ANALOG_PD_BIT 3
`define CRUDE_OFF_BIT 3
`define REF_KEEP_BIT 2

// ****************************************
// Reset values
// ****************************************
`define ANALOG_PD_RST 1'b1
`define IRQ_CFG_RST 8'h00
`define PLUG_CTL_RST 5'h00
`define FAST_CHG_RST 2'h0

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 40000000
`define PLUG_BASE_MS 32
`define BTN_BASE_MS 8
`define IRQ_PULSE_CYC 4

// ****************************************
// Host register offsets (Wishbone bytes)
// ****************************************
`define HOST_CMD 32'h0000_0000
`define HOST_STATUS 32'h0000_0004

`endif

//--- hsd_pkg.sv
`default_nettype none
package hsd_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] reg_addr_t;
    typedef enum {H_IDLE, H_WAIT} host_state_t;
endpackage : hsd_pkg
`default_nettype wire

//--- hsd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hsd_link_if;
    import hsd_pkg::*;
    // Register access
    logic req;
    logic we;
    logic page;
    reg_addr_t addr;
    byte_t wdata;
    logic ack;
    byte_t rdata;
    // Output pins that may carry interrupts
    logic gpio_pin;
    logic dout_pin;
    logic miso_pin;

    modport dev (input req, we, page, addr, wdata, output ack, rdata, gpio_pin, dout_pin, miso_pin);
    modport host (output req, we, page, addr, wdata, input ack, rdata, gpio_pin, dout_pin, miso_pin);
endinterface : hsd_link_if
`default_nettype wire

//--- hsd_device.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hsd_regs.svh"

//Contract
// - Detection runs only while enable bit set
// - Plug debounce 32 to 512 ms selectable
// - Button debounce 8 to 32 ms selectable; code gives 32 ms while detecting, as the select shares bit1 with the enable
// - Live button and plug state readable
// - Button press latches sticky flag bit5
// - Plug insert or removal latches bit4
// - Sticky flags cleared only by read
// - Headset type reported after insertion
// - Detection needs analog supply and power
// - Two interrupts, separately configured
// - Any source combination triggers each interrupt
// - Interrupts routable to three output pins
// - Config bit0 selects pulse or series
// - Series runs until flag registers read
// - Reference follows analog block power
// - Keep bit holds reference powered
// - Fast charge selectable, off after reset
// - Software powers analog down on supply loss
// - Software enables crude generator without supply
// - Soft reset bit restores defaults
module hsd_device #(
    parameter int PLUG_BASE_CYC = `PLUG_BASE_MS * (`CLK_HZ / 1000),
    parameter int BTN_BASE_CYC = `BTN_BASE_MS * (`CLK_HZ / 1000),
    parameter int PULSE_CYC = `IRQ_PULSE_CYC,
    parameter int CNT_W = 25
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Link to host
    hsd_link_if.dev link,
    // Jack sense from pins
    input wire logic plug_sense,
    input wire logic button_sense,
    input wire logic [1:0] headset_type,
    // Supplies and analog state
    input wire logic analog_core_supply,
    input wire logic analog_blocks_on,
    // Other codec events, one-cycle pulses
    input wire logic drc_event,
    input wire logic agc_event,
    input wire logic overcurrent_event,
    input wire logic overflow_event,
    input wire logic measure_event,
    // Power control and interrupt outputs
    output logic ref_power_on,
    output logic [1:0] fast_charge_sel,
    output logic analog_power_down,
    output logic crude_gen_off,
    output logic first_irq_out,
    output logic second_irq_out
);
    import hsd_pkg::*;

    // Widest window must fit the counter, pulse phase must fit eight bits
    if (PLUG_BASE_CYC * 16 >= 2 ** CNT_W || BTN_BASE_CYC * 4 >= 2 ** CNT_W
            || PULSE_CYC < 1 || PULSE_CYC > 127) begin : g_bad_params
        $error("hsd_device: parameters out of range");
    end

    // ****************************************
    // Register state
    // ****************************************
    logic rst_all, sw_rst_r, page_r;
    logic [4:0] plug_ctl_r;
    logic [1:0] type_r, f42_r, f45_r;
    logic [2:0] f44_r;
    logic [7:0] cfg_r [2];
    logic [1:0] gpio_sel_r, dout_sel_r, miso_sel_r;
    logic ref_keep_r, ack_r;
    logic acc, wr, rd;
    byte_t rdata_r;

    assign rst_all = srst | sw_rst_r;
    assign acc = ce & link.req & ~ack_r;
    assign wr = acc & link.we;
    assign rd = acc & ~link.we;

    // ****************************************
    // Debounce, plug is ch0 and button ch1
    // ****************************************
    logic det_active;
    logic [1:0] raw_s1, raw_s2, stable_r, evt_r;
    logic [CNT_W-1:0] win [2];
    logic [2:0] plug_sel;
    logic [1:0] btn_sel;

    assign det_active = plug_ctl_r[`DET_EN_BIT] & analog_core_supply & ~analog_power_down;
    assign plug_sel = plug_ctl_r[4:2];
    assign btn_sel = plug_ctl_r[1:0]; // Shares bit1 with the enable
    assign win[0] = CNT_W'(PLUG_BASE_CYC) << ((plug_sel > 3'd4) ? 3'd4 : plug_sel);
    assign win[1] = CNT_W'(BTN_BASE_CYC) << ((btn_sel > 2'd2) ? 2'd2 : btn_sel);

    always_ff @(posedge clk) begin
        if (srst) begin
            raw_s1 <= 2'h0;
            raw_s2 <= 2'h0;
        end else if (ce) begin
            raw_s1 <= {button_sense, plug_sense};
            raw_s2 <= raw_s1;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_dbc
        logic [CNT_W-1:0] cnt_r;
        always_ff @(posedge clk) begin
            if (rst_all || (ce && !det_active)) begin
                cnt_r <= '0;
                stable_r[i] <= 1'b0;
                evt_r[i] <= 1'b0;
            end else if (ce) begin
                evt_r[i] <= 1'b0;
                if (raw_s2[i] == stable_r[i]) begin
                    cnt_r <= '0;
                end else if (cnt_r >= win[i] - CNT_W'(1)) begin
                    cnt_r <= '0;
                    stable_r[i] <= raw_s2[i];
                    // Plug reports both edges, button only the press
                    evt_r[i] <= (i == 0) ? 1'b1 : raw_s2[i];
                end else begin
                    cnt_r <= cnt_r + CNT_W'(1);
                end
            end
        end
    end

    // ****************************************
    // Sticky flags
    // ****************************************
    logic clr42, clr44, clr45;
    logic [6:0] src;

    assign clr42 = rd && !page_r && link.addr == `P0_FLAGS_A;
    assign clr44 = rd && !page_r && link.addr == `P0_EVENT_FLAGS;
    assign clr45 = rd && !page_r && link.addr == `P0_FLAGS_C;
    assign src = {evt_r[0], evt_r[1], drc_event & ce, agc_event & ce,
                  overcurrent_event & ce, overflow_event & ce, measure_event & ce};

    always_ff @(posedge clk) begin
        if (rst_all) begin
            f42_r <= 2'h0;
            f44_r <= 3'h0;
            f45_r <= 2'h0;
        end else if (ce) begin
            f42_r <= (f42_r & {2{~clr42}}) | {src[3], src[4]};
            f44_r <= (f44_r & {3{~clr44}}) | {src[5], src[6], src[2]};
            f45_r <= (f45_r & {2{~clr45}}) | {src[0], src[1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            type_r <= 2'h0;
        end else if (ce && evt_r[0] && raw_s2[0]) begin
            type_r <= headset_type;
        end
    end

    // ****************************************
    // Interrupt generators
    // ****************************************
    logic [1:0] irq_r;
    for (genvar k = 0; k < 2; k++) begin : g_irq
        logic trig, ser_r;
        logic [7:0] pw_r, ph_r;
        assign trig = |(src & cfg_r[k][7:1]);
        always_ff @(posedge clk) begin
            if (rst_all) begin
                ser_r <= 1'b0;
                pw_r <= 8'h00;
                ph_r <= 8'h00;
                irq_r[k] <= 1'b0;
            end else if (ce) begin
                // New trigger wins over a clearing read
                if (trig && cfg_r[k][`PULSE_SERIES_BIT]) begin
                    ser_r <= 1'b1;
                end else if (clr42 || clr44 || clr45) begin
                    ser_r <= 1'b0;
                end
                if (trig && !cfg_r[k][`PULSE_SERIES_BIT]) begin
                    pw_r <= 8'(PULSE_CYC);
                end else if (pw_r != 8'h00) begin
                    pw_r <= pw_r - 8'h01;
                end
                // A stopped series still finishes the pulse in progress
                ph_r <= ((!ser_r && ph_r == 8'h00) || ph_r == 8'(2 * PULSE_CYC - 1)) ? 8'h00
                        : ph_r + 8'h01;
                irq_r[k] <= (pw_r != 8'h00)
                            || ((ser_r || ph_r != 8'h00) && ph_r < 8'(PULSE_CYC));
            end
        end
    end

    function automatic logic pin_mux(input logic [1:0] sel, input logic [1:0] irq);
        return (sel == 2'd1) ? irq[0] : (sel == 2'd2) ? irq[1] : 1'b0;
    endfunction : pin_mux

    always_ff @(posedge clk) begin
        if (rst_all) begin
            link.gpio_pin <= 1'b0;
            link.dout_pin <= 1'b0;
            link.miso_pin <= 1'b0;
            first_irq_out <= 1'b0;
            second_irq_out <= 1'b0;
        end else if (ce) begin
            link.gpio_pin <= pin_mux(gpio_sel_r, irq_r);
            link.dout_pin <= pin_mux(dout_sel_r, irq_r);
            link.miso_pin <= pin_mux(miso_sel_r, irq_r);
            first_irq_out <= irq_r[0];
            second_irq_out <= irq_r[1];
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_rst_r <= 1'b0;
        end else if (ce) begin
            sw_rst_r <= wr && !page_r && link.addr == `P0_SOFT_RESET
                        && link.wdata[`SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            page_r <= 1'b0;
            plug_ctl_r <= `PLUG_CTL_RST;
            cfg_r[0] <= `IRQ_CFG_RST;
            cfg_r[1] <= `IRQ_CFG_RST;
            gpio_sel_r <= 2'h0;
            dout_sel_r <= 2'h0;
            miso_sel_r <= 2'h0;
            crude_gen_off <= 1'b0;
            analog_power_down <= `ANALOG_PD_RST;
            ref_keep_r <= 1'b0;
            fast_charge_sel <= `FAST_CHG_RST;
        end else if (wr) begin
            if (link.addr == `PAGE_SELECT) page_r <= link.wdata[0];
            else if (!page_r) begin
                unique case (link.addr)
                    `P0_IRQ1_CFG: cfg_r[0] <= link.wdata;
                    `P0_IRQ2_CFG: cfg_r[1] <= link.wdata;
                    `P0_GPIO_CTL: gpio_sel_r <= link.wdata[1:0];
                    `P0_DOUT_CTL: dout_sel_r <= link.wdata[1:0];
                    `P0_MISO_CTL: miso_sel_r <= link.wdata[1:0];
                    `P0_PLUG_CTL: plug_ctl_r <= link.wdata[4:0];
                    default: ;
                endcase
            end else begin
                unique case (link.addr)
                    `P1_CRUDE_CTL: crude_gen_off <= link.wdata[`CRUDE_OFF_BIT];
                    `P1_ANALOG_CTL: analog_power_down <= link.wdata[`ANALOG_PD_BIT];
                    `P1_REF_CTL: begin
                        ref_keep_r <= link.wdata[`REF_KEEP_BIT];
                        fast_charge_sel <= link.wdata[1:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            ref_power_on <= 1'b0;
        end else if (ce) begin
            ref_power_on <= ref_keep_r | (~analog_power_down & (analog_blocks_on | det_active));
        end
    end

    // ****************************************
    // Link answer, one cycle after request
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (ce) begin
            ack_r <= acc;
            if (rd) begin
                rdata_r <= 8'h00;
                if (link.addr == `PAGE_SELECT) rdata_r <= {7'h00, page_r};
                else if (!page_r) begin
                    unique case (link.addr)
                        `P0_FLAGS_A: rdata_r <= {6'h00, f42_r};
                        `P0_EVENT_FLAGS: rdata_r <= {2'h0, f44_r, 3'h0};
                        `P0_FLAGS_C: rdata_r <= {6'h00, f45_r};
                        `P0_LIVE_STATUS: rdata_r <= {2'h0, stable_r[1], stable_r[0], 4'h0};
                        `P0_IRQ1_CFG: rdata_r <= cfg_r[0];
                        `P0_IRQ2_CFG: rdata_r <= cfg_r[1];
                        `P0_GPIO_CTL: rdata_r <= {6'h00, gpio_sel_r};
                        `P0_DOUT_CTL: rdata_r <= {6'h00, dout_sel_r};
                        `P0_MISO_CTL: rdata_r <= {6'h00, miso_sel_r};
                        `P0_PLUG_CTL: rdata_r <= {1'b0, type_r, plug_ctl_r};
                        default: ;
                    endcase
                end else begin
                    unique case (link.addr)
                        `P1_CRUDE_CTL: rdata_r <= {4'h0, crude_gen_off, 3'h0};
                        `P1_ANALOG_CTL: rdata_r <= {4'h0, analog_power_down, 3'h0};
                        `P1_REF_CTL: rdata_r <= {5'h00, ref_keep_r, fast_charge_sel};
                        default: ;
                    endcase
                end
            end
        end
    end

    assign link.ack = ack_r;
    assign link.rdata = rdata_r;
endmodule : hsd_device
`default_nettype wire

//--- hsd_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsd_regs.svh"

module hsd_host (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link to device
    hsd_link_if.host link
);
    import hsd_pkg::*;

    host_state_t state_r;
    logic hit, cmd_wr, stat_rd, done_r;
    byte_t rdata_r;

    // ****************************************
    // Wishbone decode
    // ****************************************
    assign hit = ce & wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign cmd_wr = hit && wb_we_i && wb_adr_i == `HOST_CMD && wb_sel_i[0];
    assign stat_rd = hit && !wb_we_i && wb_adr_i == `HOST_STATUS;

    // ****************************************
    // Link sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= H_IDLE;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.page <= 1'b0;
            link.addr <= 7'h00;
            link.wdata <= 8'h00;
            rdata_r <= 8'h00;
        end else if (ce) begin
            unique case (state_r)
                H_IDLE: begin
                    // A command while busy is dropped
                    if (cmd_wr) begin
                        link.req <= 1'b1;
                        link.wdata <= wb_dat_i[7:0];
                        link.addr <= wb_dat_i[14:8];
                        link.page <= wb_dat_i[16];
                        link.we <= wb_dat_i[17];
                        state_r <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (link.ack) begin
                        link.req <= 1'b0;
                        rdata_r <= link.rdata;
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // Done stays set over a status read that meets a new completion
    always_ff @(posedge clk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= (done_r & ~stat_rd) | (state_r == H_WAIT && link.ack);
        end
    end

    // ****************************************
    // Wishbone answer, one cycle after strobe
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= hit;
            wb_dat_o <= 32'h0000_0000;
            if (stat_rd) begin
                wb_dat_o <= {19'h0_0000, link.miso_pin, link.dout_pin, link.gpio_pin,
                             done_r, state_r == H_WAIT, rdata_r};
            end
        end
    end
endmodule : hsd_host
`default_nettype wire

//--- hsd_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hsd_link_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic page,
    input wire hsd_pkg::reg_addr_t addr,
    input wire hsd_pkg::byte_t wdata,
    input wire logic ack,
    input wire hsd_pkg::byte_t rdata,
    input wire logic gpio_pin,
    input wire logic dout_pin,
    input wire logic miso_pin
);
    import hsd_pkg::*;
    // ********
    // Routing shadow
    // ********
    logic [1:0] gpio_ctl_r;
    logic wr_ack;
    assign wr_ack = ack && we && !page;
    // Shadow updates no later than the pin, so the pin never leads it
    always_ff @(posedge clk) begin
        if (srst) begin
            gpio_ctl_r <= 2'h0;
        end else if (wr_ack && addr == 7'h34) begin
            gpio_ctl_r <= wdata[1:0];
        end else if (wr_ack && addr == 7'h01 && wdata[0]) begin
            gpio_ctl_r <= 2'h0;
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_ack_after_req: assert property (req && !ack |=> ack)
        else $error("link ack missing one cycle after request");
    a_ack_one_cycle: assert property (ack |=> !ack && !req)
        else $error("link ack or request held past answer");
    a_req_stable: assert property (req && !ack |=> $stable(addr) && $stable(we)
        && $stable(wdata) && $stable(page))
        else $error("link request changed before ack");
    a_rdata_hold: assert property ($changed(rdata) |-> ack && !we)
        else $error("read data changed outside a read answer");
    a_gpio_routed: assert property (gpio_pin |-> gpio_ctl_r == 2'h1 || gpio_ctl_r == 2'h2)
        else $error("gpio pin active while not routed");
    a_gpio_width: assert property ($rose(gpio_pin) |-> gpio_pin[*4] ##1 !gpio_pin)
        else $error("gpio pulse width wrong");
    a_dout_width: assert property ($rose(dout_pin) |-> dout_pin[*4] ##1 !dout_pin)
        else $error("dout pulse width wrong");
    a_soft_idle: assert property (wr_ack && addr == 7'h01 && wdata[0] |->
        ##[1:3] (!gpio_pin && !dout_pin && !miso_pin))
        else $error("pins not idle after soft reset");
    c_gpio_pulse: cover property ($rose(gpio_pin));
    c_dout_pulse: cover property ($rose(dout_pin));
    c_read_data: cover property (ack && !we && rdata != 8'h00);
endmodule : hsd_link_properties
`default_nettype wire

//--- headset_detect_event_interrupts_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module headset_detect_event_interrupts_tb_top;
    import hsd_pkg::*;
    // ********
    // Stimulus and wiring
    // ********
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0000_0000, wb_dat = 32'h0000_0000, wb_rd;
    logic wb_ack;
    logic plug = 1'b0, btn = 1'b0, sup = 1'b0, blocks = 1'b0;
    logic [1:0] htype = 2'h0;
    logic [4:0] ev = 5'h00;
    logic ref_on, apd, crude_off, irq1, irq2;
    logic [1:0] fchg;
    int mismatches = 0, cmp_count = 0, cycles = 0, gh, dr, mh;
    hsd_link_if link ();
    always #12.5 clk = ~clk;
    hsd_host hsd_host_i (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .link(link));
    // Short debounce bases keep the run brief; windows scale from them
    hsd_device #(.PLUG_BASE_CYC(8), .BTN_BASE_CYC(4)) hsd_device_i (
        .clk(clk), .srst(srst), .ce(ce), .link(link), .plug_sense(plug), .button_sense(btn),
        .headset_type(htype), .analog_core_supply(sup), .analog_blocks_on(blocks),
        .drc_event(ev[4]), .agc_event(ev[3]), .overcurrent_event(ev[2]),
        .overflow_event(ev[1]), .measure_event(ev[0]), .ref_power_on(ref_on),
        .fast_charge_sel(fchg), .analog_power_down(apd), .crude_gen_off(crude_off),
        .first_irq_out(irq1), .second_irq_out(irq2));
    hsd_link_properties hsd_link_properties_i (.clk(clk), .srst(srst), .req(link.req),
        .we(link.we), .page(link.page), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .gpio_pin(link.gpio_pin), .dout_pin(link.dout_pin),
        .miso_pin(link.miso_pin));
    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb_cycle(input logic w, input logic [31:0] a, input logic [31:0] d,
                            output logic [31:0] r);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1) @(posedge clk);
        r = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb_cycle
    task automatic link_op(input logic w, input logic pg, input reg_addr_t a, input byte_t d,
                           output byte_t r);
        logic [31:0] s;
        wb_cycle(1'b1, 32'h0000_0000, {14'h0, w, pg, 1'b0, a, d}, s);
        s = 32'h0000_0000;
        // Done is sticky, so polling can never miss a completion
        while (s[9] !== 1'b1) wb_cycle(1'b0, 32'h0000_0004, 32'h0000_0000, s);
        r = s[7:0];
    endtask : link_op
    task automatic wr(input logic pg, input reg_addr_t a, input byte_t d);
        byte_t r;
        link_op(1'b1, pg, 7'h00, {7'h00, pg}, r);
        link_op(1'b1, pg, a, d, r);
    endtask : wr
    task automatic rd(input reg_addr_t a, output byte_t r);
        link_op(1'b1, 1'b0, 7'h00, 8'h00, r);
        link_op(1'b0, 1'b0, a, 8'h00, r);
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    task automatic fire(input logic [4:0] e);
        ev <= e;
        @(posedge clk);
        ev <= 5'h00;
    endtask : fire
    task automatic watch(input int n);
        logic last;
        last = link.dout_pin;
        gh = 0;
        dr = 0;
        mh = 0;
        repeat (n) begin
            @(posedge clk);
            gh += (link.gpio_pin === 1'b1);
            dr += (link.dout_pin === 1'b1 && last !== 1'b1);
            mh += (link.miso_pin === 1'b1);
            last = link.dout_pin;
        end
    endtask : watch
    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        byte_t r;
        check(fchg, 2'h0);
        check(ref_on, 1'b0);
        check(apd, 1'b1);
        rd(7'h30, r);
        check(r, 8'h00);
        rd(7'h43, r);
        check(r, 8'h00);
    endtask : t_reset
    task automatic t_power;
        // Supply first, then crude generator off, then master power on
        sup <= 1'b1;
        wr(1'b1, 7'h01, 8'h08);
        check(crude_off, 1'b1);
        wr(1'b1, 7'h02, 8'h00);
        check(apd, 1'b0);
        blocks <= 1'b1;
        wait_cyc(4);
        check(ref_on, 1'b1);
        blocks <= 1'b0;
        wait_cyc(4);
        check(ref_on, 1'b0);
        wr(1'b1, 7'h7B, 8'h05);
        check({ref_on, fchg}, 3'h5);
    endtask : t_power
    task automatic t_detect;
        byte_t r;
        plug <= 1'b1;
        htype <= 2'h2;
        wait_cyc(300);
        rd(7'h2C, r);
        check(r, 8'h00);
        wr(1'b0, 7'h43, 8'h02);
        wait_cyc(40);
        rd(7'h2E, r);
        check(r, 8'h10);
        rd(7'h2C, r);
        check(r, 8'h10);
        rd(7'h2C, r);
        check(r, 8'h00);
        rd(7'h43, r);
        check(r, 8'h42);
        // Longest plug window, 128 cycles, and a 16-cycle button window
        wr(1'b0, 7'h43, 8'h12);
        plug <= 1'b0;
        wait_cyc(40);
        rd(7'h2C, r);
        check(r, 8'h00);
        wait_cyc(150);
        rd(7'h2C, r);
        check(r, 8'h10);
        btn <= 1'b1;
        wait_cyc(40);
        rd(7'h2E, r);
        check(r, 8'h20);
        rd(7'h2C, r);
        check(r, 8'h20);
        btn <= 1'b0;
        wait_cyc(40);
        rd(7'h2C, r);
        check(r, 8'h00);
    endtask : t_detect
    task automatic t_irq;
        byte_t r;
        wr(1'b0, 7'h34, 8'h01);
        wr(1'b0, 7'h35, 8'h02);
        wr(1'b0, 7'h30, 8'h28);
        wr(1'b0, 7'h31, 8'h05);
        fire(5'h04);
        watch(30);
        check(gh, 4);
        check(dr, 0);
        fire(5'h10);
        watch(30);
        check(gh, 4);
        fire(5'h02);
        watch(40);
        check(gh, 0);
        check(dr >= 3, 1'b1);
        rd(7'h2D, r);
        check(r, 8'h01);
        watch(20);
        watch(40);
        check(dr, 0);
        check(mh, 0);
    endtask : t_irq
    task automatic t_freeze;
        byte_t r;
        // A frozen block must not take the overflow event
        ce <= 1'b0;
        fire(5'h02);
        wait_cyc(4);
        ce <= 1'b1;
        watch(20);
        check(dr, 0);
        rd(7'h2D, r);
        check(r, 8'h00);
        fire(5'h01);
        rd(7'h2D, r);
        check(r, 8'h02);
    endtask : t_freeze
    task automatic t_soft;
        byte_t r;
        wr(1'b0, 7'h01, 8'h01);
        rd(7'h30, r);
        check(r, 8'h00);
        rd(7'h34, r);
        check(r, 8'h00);
        check(apd, 1'b1);
    endtask : t_soft
    task automatic summarize;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_power();
        t_detect();
        t_irq();
        t_freeze();
        t_soft();
        summarize();
    end
endmodule : headset_detect_event_interrupts_tb_top
`default_nettype wire
